// >>> gbw_defs.svh
`ifndef GBW_DEFS_SVH
`define GBW_DEFS_SVH

// word addresses inside the USER bank
`define GBW_CTRL_WORD 10'h002
`define GBW_PTR_WORD 10'h003

// control/status field positions
`define GBW_BWE_BIT 0
`define GBW_AUTO_BIT 1
`define GBW_LIVE_BIT 15

// reset values of the shadow copies before the power-up load
`define GBW_CTRL_RESET 16'h0000
`define GBW_PTR_RESET 16'h0000

// command field values
`define GBW_USER_BANK 2'b11
`define GBW_PTR_RAW 16'h3FFF
`define GBW_PTR_EBV 16'hF7FF
`define GBW_MAX_WORDS 8'h7F

`endif

// >>> gbw_pkg.sv
package gbw_pkg;

  typedef enum logic [8:0] {
    ST_INIT_A = 9'b0_0000_0001,
    ST_INIT_B = 9'b0_0000_0010,
    ST_INIT_C = 9'b0_0000_0100,
    ST_INIT_D = 9'b0_0000_1000,
    ST_IDLE = 9'b0_0001_0000,
    ST_RD_MEM = 9'b0_0010_0000,
    ST_RD_DONE = 9'b0_0100_0000,
    ST_BW_DATA = 9'b0_1000_0000,
    ST_BW_REPLY = 9'b1_0000_0000
  } gbw_state_t;

endpackage

// >>> gbw_mem.sv
`timescale 1ns/1ps
// nonvolatile array: no reset, contents survive a power cycle
module gbw_mem #(
  parameter int AW = 10,
  parameter int DW = 16
) (
  input wire logic mclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule

// >>> gbw_block_write.sv
`timescale 1ns/1ps
`include "gbw_defs.svh"
// Notes on behaviour
// - block write only when enable bit set
// - enable takes effect after power cycle only
// - start address from stored pointer, not command
// - payload at most 127 words
// - oversize payload written but never acknowledged ok
// - block write never changes stored pointer
// - auto advance one: start at pointer plus one
// - auto advance zero: start at pointer
// - control word 0x002, pointer word 0x003
module gbw_block_write #(
  parameter int AW = 10,
  parameter int CW = 8
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic wr_req,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic rd_req,
  input wire logic [AW-1:0] rd_addr,
  input wire logic bw_start,
  input wire logic [1:0] bw_bank,
  input wire logic [15:0] bw_word_ptr,
  input wire logic [CW-1:0] bw_word_cnt,
  input wire logic bw_data_valid,
  input wire logic [15:0] bw_data,
  input wire logic bw_end,
  input wire logic bw_crc_ok,
  output logic acc_ready,
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic reply_valid,
  output logic reply_ok,
  output logic block_write_live
);

  localparam logic [AW-1:0] CTRL_A = AW'(`GBW_CTRL_WORD);
  localparam logic [AW-1:0] PTR_A = AW'(`GBW_PTR_WORD);
  localparam logic [CW-1:0] MAX_W = CW'(`GBW_MAX_WORDS);

  gbw_pkg::gbw_state_t state_r, state_nxt;
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [15:0] ptr_r, ptr_nxt;
  logic live_r, live_nxt;
  logic mem_we_r, mem_we_nxt;
  logic [AW-1:0] mem_waddr_r, mem_waddr_nxt;
  logic [15:0] mem_wdata_r, mem_wdata_nxt;
  logic mem_re_r, mem_re_nxt;
  logic [AW-1:0] mem_raddr_r, mem_raddr_nxt;
  logic [15:0] mem_rdata;
  logic acc_ready_r, acc_ready_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic [15:0] rd_data_r, rd_data_nxt;
  logic reply_valid_r, reply_valid_nxt;
  logic reply_ok_r, reply_ok_nxt;
  logic hdr_ok_r, hdr_ok_nxt;
  logic crc_ok_r, crc_ok_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [CW-1:0] got_r, got_nxt;
  logic [AW-1:0] cur_addr_r, cur_addr_nxt;

  function automatic logic is_reg_word(input logic [AW-1:0] a);
    is_reg_word = (a == CTRL_A) || (a == PTR_A);
  endfunction

  function automatic logic [15:0] ctrl_view(input logic [15:0] c, input logic live);
    ctrl_view = c;
    ctrl_view[`GBW_LIVE_BIT] = live;
  endfunction

  gbw_mem #(
    .AW(AW),
    .DW(16)
  ) u_mem (
    .mclk(mclk),
    .we(mem_we_r),
    .waddr(mem_waddr_r),
    .wdata(mem_wdata_r),
    .re(mem_re_r),
    .raddr(mem_raddr_r),
    .rdata(mem_rdata)
  );

  always_comb begin
    state_nxt = state_r;
    ctrl_nxt = ctrl_r;
    ptr_nxt = ptr_r;
    live_nxt = live_r;
    mem_we_nxt = 1'b0;
    mem_waddr_nxt = mem_waddr_r;
    mem_wdata_nxt = mem_wdata_r;
    mem_re_nxt = 1'b0;
    mem_raddr_nxt = mem_raddr_r;
    rd_valid_nxt = 1'b0;
    rd_data_nxt = rd_data_r;
    reply_valid_nxt = 1'b0;
    reply_ok_nxt = reply_ok_r;
    hdr_ok_nxt = hdr_ok_r;
    crc_ok_nxt = crc_ok_r;
    cnt_nxt = cnt_r;
    got_nxt = got_r;
    cur_addr_nxt = cur_addr_r;
    case (state_r)
      // power-up load of the control and pointer words from the array
      gbw_pkg::ST_INIT_A: begin
        mem_re_nxt = 1'b1;
        mem_raddr_nxt = CTRL_A;
        state_nxt = gbw_pkg::ST_INIT_B;
      end
      gbw_pkg::ST_INIT_B: begin
        mem_re_nxt = 1'b1;
        mem_raddr_nxt = PTR_A;
        state_nxt = gbw_pkg::ST_INIT_C;
      end
      gbw_pkg::ST_INIT_C: begin
        ctrl_nxt = ctrl_view(mem_rdata, 1'b0);
        // the enable bit is sampled here and nowhere else
        live_nxt = mem_rdata[`GBW_BWE_BIT];
        state_nxt = gbw_pkg::ST_INIT_D;
      end
      gbw_pkg::ST_INIT_D: begin
        ptr_nxt = mem_rdata;
        state_nxt = gbw_pkg::ST_IDLE;
      end
      gbw_pkg::ST_IDLE: begin
        if (bw_start && live_r) begin
          hdr_ok_nxt = (bw_bank == `GBW_USER_BANK) &&
                       ((bw_word_ptr == `GBW_PTR_EBV) || (bw_word_ptr == `GBW_PTR_RAW));
          cnt_nxt = bw_word_cnt;
          got_nxt = '0;
          // start from the stored pointer; the command address is only a marker
          if (ctrl_r[`GBW_AUTO_BIT]) begin
            cur_addr_nxt = ptr_r[AW-1:0] + AW'(1);
          end else begin
            cur_addr_nxt = ptr_r[AW-1:0];
          end
          state_nxt = gbw_pkg::ST_BW_DATA;
        end else if (bw_start) begin
          state_nxt = gbw_pkg::ST_IDLE;
        end else if (rd_req) begin
          mem_re_nxt = 1'b1;
          mem_raddr_nxt = rd_addr;
          state_nxt = gbw_pkg::ST_RD_MEM;
        end else if (wr_req) begin
          mem_we_nxt = 1'b1;
          mem_waddr_nxt = wr_addr;
          mem_wdata_nxt = wr_data;
          if (wr_addr == CTRL_A) begin
            // the live bit is status only; a write cannot make it stick
            ctrl_nxt = ctrl_view(wr_data, 1'b0);
            mem_wdata_nxt = ctrl_view(wr_data, 1'b0);
          end else if (wr_addr == PTR_A) begin
            ptr_nxt = wr_data;
          end
        end
      end
      gbw_pkg::ST_RD_MEM: begin
        state_nxt = gbw_pkg::ST_RD_DONE;
      end
      gbw_pkg::ST_RD_DONE: begin
        rd_valid_nxt = 1'b1;
        if (mem_raddr_r == CTRL_A) begin
          rd_data_nxt = ctrl_view(ctrl_r, live_r);
        end else if (mem_raddr_r == PTR_A) begin
          rd_data_nxt = ptr_r;
        end else begin
          rd_data_nxt = mem_rdata;
        end
        state_nxt = gbw_pkg::ST_IDLE;
      end
      gbw_pkg::ST_BW_DATA: begin
        if (bw_data_valid && (got_r != cnt_r)) begin
          got_nxt = got_r + CW'(1);
          cur_addr_nxt = cur_addr_r + AW'(1);
          // oversize payloads are still written; register words are never hit
          if (hdr_ok_r && !is_reg_word(cur_addr_r)) begin
            mem_we_nxt = 1'b1;
            mem_waddr_nxt = cur_addr_r;
            mem_wdata_nxt = bw_data;
          end
        end
        if (bw_end) begin
          crc_ok_nxt = bw_crc_ok;
          state_nxt = gbw_pkg::ST_BW_REPLY;
        end
      end
      gbw_pkg::ST_BW_REPLY: begin
        reply_valid_nxt = 1'b1;
        reply_ok_nxt = hdr_ok_r && crc_ok_r && (got_r == cnt_r) &&
                       (cnt_r != '0) && (cnt_r <= MAX_W);
        state_nxt = gbw_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = gbw_pkg::ST_INIT_A;
      end
    endcase
    acc_ready_nxt = (state_nxt == gbw_pkg::ST_IDLE);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= gbw_pkg::ST_INIT_A;
      ctrl_r <= `GBW_CTRL_RESET;
      ptr_r <= `GBW_PTR_RESET;
      live_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_waddr_r <= '0;
      mem_wdata_r <= 16'h0000;
      mem_re_r <= 1'b0;
      mem_raddr_r <= '0;
      acc_ready_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r <= 16'h0000;
      reply_valid_r <= 1'b0;
      reply_ok_r <= 1'b0;
      hdr_ok_r <= 1'b0;
      crc_ok_r <= 1'b0;
      cnt_r <= '0;
      got_r <= '0;
      cur_addr_r <= '0;
    end else begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      ptr_r <= ptr_nxt;
      live_r <= live_nxt;
      mem_we_r <= mem_we_nxt;
      mem_waddr_r <= mem_waddr_nxt;
      mem_wdata_r <= mem_wdata_nxt;
      mem_re_r <= mem_re_nxt;
      mem_raddr_r <= mem_raddr_nxt;
      acc_ready_r <= acc_ready_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
      reply_valid_r <= reply_valid_nxt;
      reply_ok_r <= reply_ok_nxt;
      hdr_ok_r <= hdr_ok_nxt;
      crc_ok_r <= crc_ok_nxt;
      cnt_r <= cnt_nxt;
      got_r <= got_nxt;
      cur_addr_r <= cur_addr_nxt;
    end
  end

  assign acc_ready = acc_ready_r;
  assign rd_valid = rd_valid_r;
  assign rd_data = rd_data_r;
  assign reply_valid = reply_valid_r;
  assign reply_ok = reply_ok_r;
  assign block_write_live = live_r;

  a_disabled_ignored: assert property (@(posedge mclk) disable iff (!nrst)
    (state_r == gbw_pkg::ST_IDLE && bw_start && !live_r) |=> (state_r == gbw_pkg::ST_IDLE))
    else $error("block write taken while disabled");

  a_live_only_init: assert property (@(posedge mclk) disable iff (!nrst)
    (state_r != gbw_pkg::ST_INIT_C) |=> $stable(live_r))
    else $error("enable changed outside power-up load");

  a_start_auto: assert property (@(posedge mclk) disable iff (!nrst)
    (state_r == gbw_pkg::ST_IDLE && bw_start && live_r && ctrl_r[`GBW_AUTO_BIT])
    |=> (cur_addr_r == $past(ptr_r[AW-1:0]) + AW'(1)))
    else $error("auto advance start address wrong");

  a_start_plain: assert property (@(posedge mclk) disable iff (!nrst)
    (state_r == gbw_pkg::ST_IDLE && bw_start && live_r && !ctrl_r[`GBW_AUTO_BIT])
    |=> (cur_addr_r == $past(ptr_r[AW-1:0])))
    else $error("plain start address wrong");

  a_ptr_kept: assert property (@(posedge mclk) disable iff (!nrst)
    (state_r == gbw_pkg::ST_BW_DATA || state_r == gbw_pkg::ST_BW_REPLY)
    |=> ($stable(ptr_r) && !(mem_we_r && mem_waddr_r == PTR_A)))
    else $error("block write touched the pointer");

  a_oversize_fail: assert property (@(posedge mclk) disable iff (!nrst)
    (state_r == gbw_pkg::ST_BW_REPLY && cnt_r > MAX_W) |=> (reply_valid_r && !reply_ok_r))
    else $error("oversize payload acknowledged");

  a_addr_ascend: assert property (@(posedge mclk) disable iff (!nrst)
    (state_r == gbw_pkg::ST_BW_DATA && bw_data_valid && got_r != cnt_r && hdr_ok_r &&
     !is_reg_word(cur_addr_r)) |=> (mem_we_r && mem_waddr_r == $past(cur_addr_r) && mem_wdata_r == $past(bw_data)))
    else $error("payload word at wrong address");

  a_ptr_readback: assert property (@(posedge mclk) disable iff (!nrst)
    (state_r == gbw_pkg::ST_IDLE && !bw_start && rd_req && rd_addr == PTR_A)
    |=> ##2 (rd_valid_r && rd_data_r == ptr_r))
    else $error("pointer word readback wrong");

endmodule

// >>> gbw_reader.sv
`timescale 1ns/1ps
// interrogator side: every field changes at the falling edge only
module gbw_reader (
  input wire logic mclk,
  input wire logic acc_ready,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  input wire logic reply_valid,
  input wire logic reply_ok,
  output logic wr_req,
  output logic [9:0] wr_addr,
  output logic [15:0] wr_data,
  output logic rd_req,
  output logic [9:0] rd_addr,
  output logic bw_start,
  output logic [1:0] bw_bank,
  output logic [15:0] bw_word_ptr,
  output logic [7:0] bw_word_cnt,
  output logic bw_data_valid,
  output logic [15:0] bw_data,
  output logic bw_end,
  output logic bw_crc_ok
);
  initial begin
    {wr_req, rd_req, bw_start, bw_data_valid, bw_end, bw_crc_ok} = 6'h00;
    {wr_addr, rd_addr, bw_bank, bw_word_ptr, bw_word_cnt} = 46'h0000_0000_0000;
    {wr_data, bw_data} = 32'h0000_0000;
  end

  task automatic idle_wait();
    int n = 0;
    @(negedge mclk);
    while (acc_ready !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    idle_wait();
    wr_req = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge mclk);
    wr_req = 1'b0;
    // released data must not keep looking valid
    wr_data = ~d;
    repeat (2) @(negedge mclk);
  endtask

  task automatic rd(input logic [9:0] a, output logic [15:0] d, output logic got);
    idle_wait();
    rd_req = 1'b1;
    rd_addr = a;
    @(negedge mclk);
    rd_req = 1'b0;
    repeat (2) @(negedge mclk);
    got = rd_valid;
    d = rd_data;
  endtask

  // header, payload, then end of frame with a good check
  task automatic bw(input logic [15:0] ptr, input logic [7:0] cnt, input int nw, input logic [15:0] base,
                    output logic seen, output logic ok);
    idle_wait();
    bw_start = 1'b1;
    bw_bank = 2'b11;
    bw_word_ptr = ptr;
    bw_word_cnt = cnt;
    @(negedge mclk);
    bw_start = 1'b0;
    // valid stays high across back-to-back words
    for (int k = 0; k < nw; k++) begin
      bw_data_valid = 1'b1;
      bw_data = base + 16'(k);
      @(negedge mclk);
    end
    bw_data_valid = 1'b0;
    bw_data = ~bw_data;
    bw_end = 1'b1;
    bw_crc_ok = 1'b1;
    @(negedge mclk);
    bw_end = 1'b0;
    bw_crc_ok = 1'b0;
    seen = 1'b0;
    ok = 1'b0;
    repeat (4) begin
      if (reply_valid === 1'b1) begin
        seen = 1'b1;
        ok = reply_ok;
      end
      @(negedge mclk);
    end
  endtask
endmodule

// >>> tb_gen2_pointer_block_write.sv
`timescale 1ns/1ps
module tb_gen2_pointer_block_write;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic wr_req, rd_req, bw_start, bw_data_valid, bw_end, bw_crc_ok;
  logic [9:0] wr_addr, rd_addr;
  logic [15:0] wr_data, bw_word_ptr, bw_data, rd_data;
  logic [1:0] bw_bank;
  logic [7:0] bw_word_cnt;
  logic acc_ready, rd_valid, reply_valid, reply_ok, block_write_live;
  int fails = 0;
  int compares = 0;
  int cyc = 0;

  always #2 mclk = ~mclk;

  gbw_block_write u_dut (.mclk(mclk), .nrst(nrst), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_req(rd_req), .rd_addr(rd_addr), .bw_start(bw_start), .bw_bank(bw_bank), .bw_word_ptr(bw_word_ptr),
    .bw_word_cnt(bw_word_cnt), .bw_data_valid(bw_data_valid), .bw_data(bw_data), .bw_end(bw_end),
    .bw_crc_ok(bw_crc_ok), .acc_ready(acc_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .reply_valid(reply_valid), .reply_ok(reply_ok), .block_write_live(block_write_live));

  gbw_reader u_rdr (.mclk(mclk), .acc_ready(acc_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .reply_valid(reply_valid), .reply_ok(reply_ok), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_req(rd_req), .rd_addr(rd_addr), .bw_start(bw_start), .bw_bank(bw_bank), .bw_word_ptr(bw_word_ptr),
    .bw_word_cnt(bw_word_cnt), .bw_data_valid(bw_data_valid), .bw_data(bw_data), .bw_end(bw_end),
    .bw_crc_ok(bw_crc_ok));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    if (fails == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // a missing read answer is forced to differ from the expectation
  task automatic rd_chk(input logic [9:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic g;
    u_rdr.rd(a, d, g);
    check($sformatf("word %h", a), g ? d : ~exp, exp);
  endtask

  task automatic bw_chk(input logic [15:0] ptr, input int n, input logic [15:0] base, input logic s, input logic o);
    logic seen, ok;
    u_rdr.bw(ptr, 8'(n), n, base, seen, ok);
    check("reply seen", {15'h0, seen}, {15'h0, s});
    if (s) check("reply ok", {15'h0, ok}, {15'h0, o});
  endtask

  // nonvolatile array keeps its words across this
  task automatic power_cycle();
    @(negedge mclk);
    nrst = 1'b0;
    repeat (16) @(negedge mclk);
    nrst = 1'b1;
  endtask

  task automatic t_not_live();
    u_rdr.wr(10'h002, 16'h0001);
    u_rdr.wr(10'h006, 16'h5555);
    rd_chk(10'h002, 16'h0001);
    check("live", {15'h0, block_write_live}, 16'h0000);
    bw_chk(16'hF7FF, 2, 16'hA000, 1'b0, 1'b0);
    rd_chk(10'h006, 16'h5555);
  endtask

  task automatic t_plain();
    power_cycle();
    rd_chk(10'h002, 16'h8001);
    check("live", {15'h0, block_write_live}, 16'h0001);
    u_rdr.wr(10'h003, 16'h0006);
    bw_chk(16'hF7FF, 2, 16'hA000, 1'b1, 1'b1);
    rd_chk(10'h006, 16'hA000);
    rd_chk(10'h007, 16'hA001);
    rd_chk(10'h003, 16'h0006);
  endtask

  task automatic t_auto();
    u_rdr.wr(10'h002, 16'h0003);
    rd_chk(10'h002, 16'h8003);
    bw_chk(16'h3FFF, 3, 16'hB000, 1'b1, 1'b1);
    rd_chk(10'h006, 16'hA000);
    rd_chk(10'h007, 16'hB000);
    rd_chk(10'h009, 16'hB002);
    rd_chk(10'h003, 16'h0006);
  endtask

  task automatic t_size();
    u_rdr.wr(10'h002, 16'h0001);
    u_rdr.wr(10'h003, 16'h0020);
    bw_chk(16'hF7FF, 127, 16'hC000, 1'b1, 1'b1);
    rd_chk(10'h09E, 16'hC07E);
    bw_chk(16'hF7FF, 128, 16'hD000, 1'b1, 1'b0);
    rd_chk(10'h09F, 16'hD07F);
    rd_chk(10'h003, 16'h0020);
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      close_out();
    end
  end

  initial begin
    // factory-blank array: control and pointer words start cleared
    u_dut.u_mem.mem[2] = 16'h0000;
    u_dut.u_mem.mem[3] = 16'h0000;
    repeat (16) @(negedge mclk);
    nrst = 1'b1;
    t_not_live();
    t_plain();
    t_auto();
    t_size();
    close_out();
  end
endmodule
